// ===== core/uar_pkg.sv
// Shared constants, types and helpers of the serial receive block
package uar_pkg;

  localparam logic [2:0] ADDR_STATUS  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_FORMAT  = 3'h2;
  localparam logic [2:0] ADDR_DATA    = 3'h3;

  localparam int ST_RXC_BIT      = 7;
  localparam int ST_FE_BIT       = 4;
  localparam int ST_DOR_BIT      = 3;
  localparam int ST_PE_BIT       = 2;
  localparam int ST_DBL_BIT      = 1;
  localparam int CTL_IRQEN_BIT   = 7;
  localparam int CTL_RXEN_BIT    = 4;
  localparam int CTL_SIZE2_BIT   = 2;
  localparam int CTL_NINTH_BIT   = 1;
  localparam int FMT_PAR_EN_BIT  = 5;
  localparam int FMT_PAR_ODD_BIT = 4;
  localparam int FMT_STOP_BIT    = 3;
  localparam int FMT_SIZE_HI     = 2;
  localparam int FMT_SIZE_LO     = 1;

  localparam logic [2:0] RST_CHAR_SIZE = 3'h3;
  localparam logic       RST_FLAG      = 1'b0;

  localparam logic [4:0] SPB_NORMAL        = 5'h10;
  localparam logic [4:0] SPB_DOUBLE        = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN         = 5'h02;

  localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
  localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       fe;
    logic       dor;
    logic       pe;
  } uar_entry_t;

  typedef struct packed {
    logic       par_en;
    logic       par_odd;
    logic [2:0] size;
  } uar_cfg_t;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority3

  // Reserved size codes fall back to their low two bits
  function automatic logic [3:0] data_bits(input logic [2:0] size);
    data_bits = (size == CHAR_SIZE_NINE) ? CHAR_BITS_NINE
                                         : CHAR_BITS_BASE + {2'h0, size[1:0]};
  endfunction : data_bits

endpackage : uar_pkg

// ===== core/uar_fifo.sv
// Small flop-based receive FIFO with flush
`timescale 1ns/100ps
module uar_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic             flush_in,
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  input  wire logic             pop_in,
  output logic      [WIDTH-1:0] head_out,
  output logic                  empty_out,
  output logic                  full_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             do_push;
  logic             do_pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign empty_out = (count == '0);
  assign full_out  = (count == CW'(DEPTH));
  assign do_push   = push_in & ~full_out;
  assign do_pop    = pop_in & ~empty_out;
  assign head_out  = mem[rd_ptr];

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_in) begin
      if (flush_in) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (do_push) wr_ptr <= bump(wr_ptr);
        if (do_pop) rd_ptr <= bump(rd_ptr);
        if (do_push && !do_pop) count <= CW'(count + 1'b1);
        else if (do_pop && !do_push) count <= CW'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (ce_in && do_push && !flush_in) begin
      mem[wr_ptr] <= push_data_in;
    end
  end
endmodule : uar_fifo

// ===== core/uar_sampler.sv
// Oversample counter, falling edge detect and three-sample vote
`timescale 1ns/100ps
module uar_sampler (
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  input  wire logic tick_in,
  input  wire logic rxd_in,
  input  wire logic dbl_in,
  input  wire logic clear_in,
  input  wire logic arm_in,
  output logic      fall_out,
  output logic      vote_done_out,
  output logic      vote_out,
  output logic      bit_end_out
);
  import uar_pkg::*;

  logic [4:0] cnt;
  logic [4:0] spb;
  logic [4:0] first;
  logic [4:0] samp_num;
  logic       running;
  logic       prev_line;
  logic [1:0] early;

  assign spb      = dbl_in ? SPB_DOUBLE : SPB_NORMAL;
  assign first    = dbl_in ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  assign running  = (cnt != '0);
  assign samp_num = (cnt == spb) ? 5'h01 : 5'(cnt + 5'h01);
  assign fall_out = tick_in & prev_line & ~rxd_in;
  assign vote_done_out = tick_in & running & ~arm_in
                         & (samp_num == 5'(first + VOTE_SPAN));
  assign vote_out    = majority3({early, rxd_in});
  assign bit_end_out = tick_in & running & ~arm_in & (samp_num == spb);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) prev_line <= 1'b1;
    else if (ce_in && tick_in) prev_line <= rxd_in;
  end

  // First low sample is number 1; timing restarts on every start edge
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      if (clear_in) cnt <= '0;
      else if (tick_in && arm_in) cnt <= 5'h01;
      else if (tick_in && running) cnt <= samp_num;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      early <= 2'h0;
    end else if (ce_in && tick_in && running) begin
      if (samp_num == first) early[1] <= rxd_in;
      if (samp_num == 5'(first + 5'h01)) early[0] <= rxd_in;
    end
  end
endmodule : uar_sampler

// ===== core/uar_rx_top.sv
// Asynchronous serial receiver with register port and two-entry receive FIFO
`timescale 1ns/100ps
module uar_rx_top #(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  input  wire logic       sample_tick_in,
  input  wire logic       serial_rx_pin_in,
  input  wire logic [2:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            rx_complete_irq_out,
  output logic            rx_pin_owned_out
);
  import uar_pkg::*;

  typedef enum logic [2:0] {
    UAR_IDLE,
    UAR_START,
    UAR_DATA,
    UAR_PARITY,
    UAR_STOP
  } uar_state_t;

  uar_state_t state;

  // Strobe qualified by the sequencer phase; shared by several decoders below
  function automatic logic in_phase(input uar_state_t now, input uar_state_t want,
                                    input logic strobe);
    in_phase = (now == want) & strobe;
  endfunction : in_phase

  logic       rx_complete_irq_enable;
  logic       receiver_enable;
  logic       double_speed_select;
  logic       stop_bits_select;
  uar_cfg_t   cfg;
  uar_cfg_t   frame_cfg;

  logic       fall;
  logic       vote_done;
  logic       vote;
  logic       bit_end;
  logic       arm;
  logic       reject;
  logic       start_ok;
  logic       frame_done;
  logic       samp_clear;

  logic [3:0] bit_idx;
  logic [3:0] nbits;
  logic [8:0] shift_data;
  logic       parity_rx;
  uar_entry_t new_entry;

  uar_entry_t hold;
  logic       hold_valid;
  logic       move_hold;
  logic       direct;
  logic       capture;

  logic       fifo_push;
  uar_entry_t fifo_push_data;
  uar_entry_t head;
  logic [11:0] head_bits;
  logic       fifo_empty;
  logic       fifo_full;
  logic       data_read;
  logic       rx_complete;

  logic [7:0] rd_mux;

  assign nbits = data_bits(frame_cfg.size);

  // Register writes; the error flags have no write path at all
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_complete_irq_enable <= RST_FLAG;
      receiver_enable        <= RST_FLAG;
      double_speed_select    <= RST_FLAG;
      stop_bits_select       <= RST_FLAG;
      cfg.par_en             <= RST_FLAG;
      cfg.par_odd            <= RST_FLAG;
      cfg.size               <= RST_CHAR_SIZE;
    end else if (ce_in && reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_STATUS: begin
          double_speed_select <= reg_wdata_in[ST_DBL_BIT];
        end
        ADDR_CONTROL: begin
          rx_complete_irq_enable <= reg_wdata_in[CTL_IRQEN_BIT];
          receiver_enable        <= reg_wdata_in[CTL_RXEN_BIT];
          cfg.size[2]            <= reg_wdata_in[CTL_SIZE2_BIT];
        end
        ADDR_FORMAT: begin
          cfg.par_en       <= reg_wdata_in[FMT_PAR_EN_BIT];
          cfg.par_odd      <= reg_wdata_in[FMT_PAR_ODD_BIT];
          stop_bits_select <= reg_wdata_in[FMT_STOP_BIT];
          cfg.size[1:0]    <= reg_wdata_in[FMT_SIZE_HI:FMT_SIZE_LO];
        end
        default: begin
        end
      endcase
    end
  end

  uar_sampler u_sampler (
    .core_clk_in   (core_clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .tick_in       (sample_tick_in),
    .rxd_in        (serial_rx_pin_in),
    .dbl_in        (double_speed_select),
    .clear_in      (samp_clear),
    .arm_in        (arm),
    .fall_out      (fall),
    .vote_done_out (vote_done),
    .vote_out      (vote),
    .bit_end_out   (bit_end)
  );

  // Edges are watched only in idle, so a frame's own data cannot re-arm it
  assign arm        = receiver_enable & in_phase(state, UAR_IDLE, fall);
  assign reject     = in_phase(state, UAR_START, vote_done) & vote;
  assign start_ok   = in_phase(state, UAR_START, vote_done) & ~vote;
  assign frame_done = in_phase(state, UAR_STOP, vote_done);
  assign samp_clear = ~receiver_enable | reject | frame_done;

  // Frame sequencer; leaving enable low drops any frame in flight
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= UAR_IDLE;
    end else if (ce_in) begin
      if (!receiver_enable) begin
        state <= UAR_IDLE;
      end else begin
        unique case (state)
          UAR_IDLE: begin
            if (arm) state <= UAR_START;
          end
          UAR_START: begin
            if (reject) state <= UAR_IDLE;
            else if (bit_end) state <= UAR_DATA;
          end
          UAR_DATA: begin
            if (bit_end && bit_idx == 4'(nbits - 4'h1)) begin
              state <= frame_cfg.par_en ? UAR_PARITY : UAR_STOP;
            end
          end
          UAR_PARITY: begin
            if (bit_end) state <= UAR_STOP;
          end
          UAR_STOP: begin
            // Back to edge watch right after the vote; later stop bits unseen
            if (vote_done) state <= UAR_IDLE;
          end
          // Unused codes of the state register fall back to edge watch
          default: begin
            state <= UAR_IDLE;
          end
        endcase
      end
    end
  end

  // Parity and size captured at the start edge so mid-frame writes leave reception alone;
  // the status PE bit is masked by the live cfg.par_en; the double speed select is not captured
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_cfg.par_en  <= RST_FLAG;
      frame_cfg.par_odd <= RST_FLAG;
      frame_cfg.size    <= RST_CHAR_SIZE;
    end else if (ce_in && arm) begin
      frame_cfg <= cfg;
    end
  end

  // Bit index restarts on every accepted edge; a rejected start leaves it unused
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_idx <= 4'h0;
    end else if (ce_in) begin
      if (arm) bit_idx <= 4'h0;
      else if (in_phase(state, UAR_DATA, bit_end)) bit_idx <= 4'(bit_idx + 4'h1);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_data <= 9'h000;
    end else if (ce_in) begin
      if (arm) shift_data <= 9'h000;
      else if (in_phase(state, UAR_DATA, vote_done)) shift_data[bit_idx] <= vote;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) parity_rx <= 1'b0;
    else if (ce_in && in_phase(state, UAR_PARITY, vote_done)) parity_rx <= vote;
  end

  // Unused data bits stay zero, so they do not disturb the parity sum
  always_comb begin
    new_entry.ninth = shift_data[8];
    new_entry.data  = shift_data[7:0];
    new_entry.fe    = ~vote;
    new_entry.dor   = 1'b0;
    new_entry.pe    = frame_cfg.par_en
                      & ((^shift_data ^ frame_cfg.par_odd) != parity_rx);
  end

  // Waiting slot between the shift register and a full FIFO
  assign move_hold = hold_valid & ~fifo_full;
  assign direct    = frame_done & ~hold_valid & ~fifo_full;
  assign capture   = frame_done & ~direct & (~hold_valid | move_hold);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_valid <= 1'b0;
    end else if (ce_in) begin
      if (!receiver_enable) hold_valid <= 1'b0;
      else if (capture) hold_valid <= 1'b1;
      else if (move_hold) hold_valid <= 1'b0;
    end
  end

  // A frame that finds the slot busy and the FIFO full is lost; a start accepted while the slot is busy and the FIFO full marks the waiting one
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold <= '0;
    end else if (ce_in) begin
      if (capture) hold <= new_entry;
      else if (start_ok && hold_valid && fifo_full) hold.dor <= 1'b1;
    end
  end

  assign fifo_push      = receiver_enable & (move_hold | direct);
  assign fifo_push_data = move_hold ? hold : new_entry;
  assign data_read      = reg_rd_in & (reg_addr_in == ADDR_DATA);

  uar_fifo #(
    .WIDTH ($bits(uar_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .ce_in        (ce_in),
    .flush_in     (~receiver_enable),
    .push_in      (fifo_push),
    .push_data_in (fifo_push_data),
    .pop_in       (data_read),
    .head_out     (head_bits),
    .empty_out    (fifo_empty),
    .full_out     (fifo_full)
  );

  // An empty FIFO reads as zero so a stale slot never shows up as data or flags
  assign head        = fifo_empty ? uar_entry_t'('0) : uar_entry_t'(head_bits);
  assign rx_complete = ~fifo_empty;

  // Status and control reads leave the FIFO alone, only a data read pops
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_in)
      ADDR_STATUS: begin
        rd_mux[ST_RXC_BIT] = rx_complete;
        rd_mux[ST_FE_BIT]  = head.fe;
        rd_mux[ST_DOR_BIT] = head.dor;
        rd_mux[ST_PE_BIT]  = head.pe & cfg.par_en;
        rd_mux[ST_DBL_BIT] = double_speed_select;
      end
      ADDR_CONTROL: begin
        rd_mux[CTL_IRQEN_BIT] = rx_complete_irq_enable;
        rd_mux[CTL_RXEN_BIT]  = receiver_enable;
        rd_mux[CTL_SIZE2_BIT] = cfg.size[2];
        rd_mux[CTL_NINTH_BIT] = head.ninth;
      end
      ADDR_FORMAT: begin
        rd_mux[FMT_PAR_EN_BIT]  = cfg.par_en;
        rd_mux[FMT_PAR_ODD_BIT] = cfg.par_odd;
        rd_mux[FMT_STOP_BIT]    = stop_bits_select;
        rd_mux[FMT_SIZE_HI:FMT_SIZE_LO] = cfg.size[1:0];
      end
      ADDR_DATA: begin
        rd_mux = head.data;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Read data stand for one enabled cycle only; every other enabled cycle returns zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) reg_rdata_out <= 8'h00;
    else if (ce_in) reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
  end

  // Request tracks FIFO occupancy only; error flags feed no interrupt
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rx_complete_irq_out <= 1'b0;
    else if (ce_in) rx_complete_irq_out <= rx_complete & rx_complete_irq_enable;
  end

  // Pin ownership lags the enable by one flop, like every other output
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rx_pin_owned_out <= 1'b0;
    else if (ce_in) rx_pin_owned_out <= receiver_enable;
  end

endmodule : uar_rx_top

// ===== verif/uar_rx_monitor.sv
// Port-level assertions for the serial receive block
`timescale 1ns/100ps
module uar_rx_monitor
  import uar_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic       ce_in,
  input wire logic       sample_tick_in,
  input wire logic       serial_rx_pin_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       rx_complete_irq_out,
  input wire logic       rx_pin_owned_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic rd_data = reg_rd_in && reg_addr_in == ADDR_DATA;
  wire logic wr_ctl  = reg_wr_in && reg_addr_in == ADDR_CONTROL;
  wire logic wd_en   = reg_wdata_in[CTL_RXEN_BIT];
  wire logic wd_dbl  = reg_wdata_in[ST_DBL_BIT];
  wire logic [2:0] rd_flags = reg_rdata_out[4:2];
  sequence s_rd(logic [2:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  sequence s_wr(logic [2:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  a_rdata_one_cycle: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_irq_needs_rxc: assert property (
    s_rd(ADDR_STATUS) ##1 rx_complete_irq_out |-> reg_rdata_out[ST_RXC_BIT])
    else $error("irq high with empty fifo");
  a_irq_hold: assert property (
    $fell(rx_complete_irq_out) |-> $past(rd_data, 2) || $past(wr_ctl, 2) || $past(wr_ctl, 3))
    else $error("irq dropped without data read");
  a_pin_follows_en: assert property (
    wr_ctl |-> ##2 rx_pin_owned_out == $past(wd_en, 2))
    else $error("pin ownership wrong");
  a_flush_on_disable: assert property (
    wr_ctl && !wd_en |-> ##3 !rx_complete_irq_out [*2])
    else $error("fifo not flushed on disable");
  a_dbl_bit_rw: assert property (
    s_wr(ADDR_STATUS) ##2 s_rd(ADDR_STATUS) |=> reg_rdata_out[ST_DBL_BIT] == $past(wd_dbl, 3))
    else $error("double speed bit lost");
  a_flags_no_write: assert property (
    s_rd(ADDR_STATUS) ##1 s_wr(ADDR_STATUS) ##1 s_rd(ADDR_STATUS)
      |=> reg_rdata_out[4:2] == $past(rd_flags, 2))
    else $error("status write changed error flags");
  a_empty_no_data: assert property (
    s_rd(ADDR_STATUS) ##1 (rd_data && !reg_rdata_out[ST_RXC_BIT]) |=> reg_rdata_out == 8'h00)
    else $error("data from empty fifo");
endmodule : uar_rx_monitor
bind uar_rx_top uar_rx_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_uar_rx_monitor (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
  .sample_tick_in(sample_tick_in), .serial_rx_pin_in(serial_rx_pin_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .rx_complete_irq_out(rx_complete_irq_out), .rx_pin_owned_out(rx_pin_owned_out)
);

// ===== verif/uar_tx_model.sv
// Behavioural remote transmitter driving the serial line and sample tick
`timescale 1ns/100ps
module uar_tx_model (
  input  wire logic        core_clk_in,
  input  wire logic        send_in,
  input  wire logic [11:0] bits_in,
  input  wire logic [3:0]  nbits_in,
  input  wire logic [4:0]  spb_in,
  output logic             tick_out,
  output logic             line_out,
  output logic             busy_out
);
  logic [1:0]  div = 2'h0;
  logic [11:0] sh;
  logic [3:0]  left;
  logic [4:0]  cnt;
  initial begin
    tick_out = 1'b0;
    line_out = 1'b1;
    busy_out = 1'b0;
  end
  // Line moves only on tick edges, so every bit spans whole sample periods
  always @(posedge core_clk_in) begin
    div      <= div + 2'h1;
    tick_out <= (div == 2'h3);
    if (send_in && !busy_out) begin
      sh       <= bits_in;
      left     <= nbits_in;
      cnt      <= 5'h00;
      busy_out <= 1'b1;
    end else if (busy_out && tick_out) begin
      if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end else if (left == 4'h0) begin
        busy_out <= 1'b0;
        line_out <= 1'b1;
      end else begin
        line_out <= sh[0];
        sh       <= sh >> 1;
        left     <= left - 4'h1;
        cnt      <= spb_in - 5'h01;
      end
    end
  end
endmodule : uar_tx_model

// ===== verif/uar_testbench.sv
// Self-checking bench for the serial receive block
`timescale 1ns/100ps
module testbench;
  import uar_pkg::*;
  logic        clk, rst_n, ce, wr, rd, send, busy, tick, line, irq, owned;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, s, c, d;
  logic [11:0] bits;
  logic [3:0]  nb;
  logic [4:0]  spb;
  int          miscompares;
  int          comparisons;
  uar_rx_top i_uar_rx_top (
    .core_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .sample_tick_in(tick),
    .serial_rx_pin_in(line), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_complete_irq_out(irq),
    .rx_pin_owned_out(owned));
  uar_tx_model i_uar_tx_model (
    .core_clk_in(clk), .send_in(send), .bits_in(bits), .nbits_in(nb), .spb_in(spb),
    .tick_out(tick), .line_out(line), .busy_out(busy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // Control and status go first because the data read pops the entry
  task automatic chk_frame(input logic [7:0] es, input logic [7:0] ec, input logic [7:0] ed);
    @(posedge clk);
    addr <= ADDR_CONTROL;
    rd   <= 1'b1;
    @(posedge clk);
    addr <= ADDR_STATUS;
    #1 c = rdata;
    @(posedge clk);
    addr <= ADDR_DATA;
    #1 s = rdata;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
    chk(c, ec);
    chk(s, es);
    chk(d, ed);
  endtask : chk_frame
  task automatic send_frame(input logic [8:0] dv, input int n, input logic pen,
                            input logic pv, input logic stop, input logic [4:0] t);
    logic [11:0] b;
    int          k;
    b = 12'h000;
    for (k = 0; k < n; k++) b[k+1] = dv[k];
    if (pen) b[n+1] = pv;
    b[n+1+pen] = stop;
    @(posedge clk);
    bits <= b;
    nb   <= 4'(n + 2 + pen);
    spb  <= t;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
    for (k = 0; k < 4000 && busy === 1'b1; k++) #10;
    chk({7'h00, busy}, 8'h00);
    repeat (4) @(posedge clk);
  endtask : send_frame
  task automatic t_basic;
    rd_reg(3'h5, s);
    chk(s, 8'h00);
    chk({6'h00, irq, owned}, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h90);
    repeat (3) @(posedge clk);
    chk({7'h00, owned}, 8'h01);
    send_frame(9'h0A5, 8, 0, 0, 1, SPB_NORMAL);
    chk({7'h00, irq}, 8'h01);
    // A data read while frozen must not pop; the frame below proves it
    @(posedge clk);
    ce   <= 1'b0;
    addr <= ADDR_DATA;
    rd   <= 1'b1;
    @(posedge clk);
    ce   <= 1'b1;
    rd   <= 1'b0;
    #1 chk(rdata, 8'h00);
    chk_frame(8'h80, 8'h90, 8'hA5);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
  endtask : t_basic
  task automatic t_frame_err;
    send_frame(9'h03C, 8, 0, 0, 0, SPB_NORMAL);
    @(posedge clk);
    addr <= ADDR_STATUS;
    rd   <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    wr    <= 1'b1;
    wdata <= 8'h00;
    #1 chk(rdata, 8'h90);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, 8'h90);
    chk_frame(8'h90, 8'h90, 8'h3C);
  endtask : t_frame_err
  task automatic t_overrun;
    logic [7:0] es [4] = '{8'h80, 8'h80, 8'h88, 8'h00};
    logic [7:0] ed [4] = '{8'h11, 8'h22, 8'h33, 8'h00};
    for (int k = 0; k < 4; k++) send_frame(9'(17 * (k + 1)), 8, 0, 0, 1, SPB_NORMAL);
    for (int k = 0; k < 4; k++) chk_frame(es[k], 8'h90, ed[k]);
    send_frame(9'h055, 8, 0, 0, 1, SPB_NORMAL);
    chk_frame(8'h80, 8'h90, 8'h55);
  endtask : t_overrun
  task automatic t_formats;
    wr_reg(ADDR_FORMAT, 8'h24);
    send_frame(9'h035, 7, 1, ~(^7'h35), 1, SPB_NORMAL);
    wr_reg(ADDR_FORMAT, 8'h04);
    rd_reg(ADDR_STATUS, s);
    chk(s, 8'h80);
    wr_reg(ADDR_FORMAT, 8'h24);
    chk_frame(8'h84, 8'h90, 8'h35);
    wr_reg(ADDR_FORMAT, 8'h34);
    send_frame(9'h035, 7, 1, ~(^7'h35), 1, SPB_NORMAL);
    chk_frame(8'h80, 8'h90, 8'h35);
    wr_reg(ADDR_FORMAT, 8'h06);
    wr_reg(ADDR_CONTROL, 8'h94);
    send_frame(9'h13C, 9, 0, 0, 1, SPB_NORMAL);
    chk_frame(8'h80, 8'h96, 8'h3C);
    wr_reg(ADDR_CONTROL, 8'h90);
    wr_reg(ADDR_STATUS, 8'h02);
    rd_reg(ADDR_STATUS, s);
    chk(s, 8'h02);
    send_frame(9'h05A, 8, 0, 0, 1, SPB_DOUBLE);
    chk_frame(8'h82, 8'h90, 8'h5A);
    wr_reg(ADDR_STATUS, 8'h00);
  endtask : t_formats
  task automatic t_glitch_disable;
    send_frame(9'h000, 0, 0, 0, 1, 5'h04);
    rd_reg(ADDR_STATUS, s);
    chk(s, 8'h00);
    send_frame(9'h00F, 8, 0, 0, 1, SPB_NORMAL);
    chk_frame(8'h80, 8'h90, 8'h0F);
    send_frame(9'h066, 8, 0, 0, 1, SPB_NORMAL);
    wr_reg(ADDR_CONTROL, 8'h80);
    repeat (3) @(posedge clk);
    chk({6'h00, irq, owned}, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h90);
    // All-ones data leaves no edge to restart on after re-enable
    fork
      send_frame(9'h0FF, 8, 0, 0, 1, SPB_NORMAL);
      begin
        repeat (200) @(posedge clk);
        wr_reg(ADDR_CONTROL, 8'h80);
        wr_reg(ADDR_CONTROL, 8'h90);
      end
    join
    rd_reg(ADDR_STATUS, s);
    chk(s, 8'h00);
  endtask : t_glitch_disable
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, send, addr, wdata, bits, nb} = '0;
    ce = 1'b1;
    spb = SPB_NORMAL;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_frame_err();
    t_overrun();
    t_formats();
    t_glitch_disable();
    end_sim();
  end
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule : testbench
